// >>> e3_oh_pkg.sv
// Constants shared by both ends of the received E3 overhead strobe link.
// Assumes one clock (mclk) for both ends; the receive line clock is a square wave divided from mclk by 8.
//
// Functional notes
// - Terminal samples marker, data, strobe together
// - Strobe high for all 16 overhead bits, one line period each
// - Marker only with first overhead bit
// - Terminal counts strobes since marked strobe
// - Order: alignment, A, N, BIP-4 bits
// - BIP-4 positions processed only when enabled
// - Terminal uses data, marker, strobe, clock
package e3_oh_pkg;
    localparam int OH_BITS = 16;
    localparam int IDX_W = 4;
    localparam int ALIGN_BITS = 10;
    localparam logic [IDX_W-1:0] IDX_FIRST = 4'h0;
    localparam logic [IDX_W-1:0] IDX_A = 4'hA;
    localparam logic [IDX_W-1:0] IDX_N = 4'hB;
    localparam logic [IDX_W-1:0] IDX_BIP_FIRST = 4'hC;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'hF;
    // Line clock period in mclk cycles; half period high, half low
    localparam int LINE_DIV = 8;
    localparam logic [2:0] DIV_LAST = 3'h7;
    localparam logic [2:0] DIV_HALF = 3'h4;
    typedef logic [OH_BITS-1:0] oh_word_t;
endpackage : e3_oh_pkg

// >>> e3_oh_link.sv
// Link between the overhead output port and the terminal equipment.
// Assumes both ends run on the same mclk.
`timescale 1ns/10ps
`default_nettype none
interface e3_oh_link;
    logic receive_line_clock;
    logic overhead_serial_out;
    logic overhead_frame_marker;
    logic overhead_bit_strobe;
    modport device (output receive_line_clock, output overhead_serial_out,
                    output overhead_frame_marker, output overhead_bit_strobe);
    modport terminal (input receive_line_clock, input overhead_serial_out,
                      input overhead_frame_marker, input overhead_bit_strobe);
endinterface : e3_oh_link
`default_nettype wire

// >>> e3_oh_device.sv
// Device end: shifts out the overhead bits of each received frame with strobe and marker.
// Assumes frame_done pulses once per frame with overhead_word stable that cycle.
`timescale 1ns/10ps
`default_nettype none
module e3_oh_device (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Framer side
    input wire logic frame_done,
    input wire e3_oh_pkg::oh_word_t overhead_word,
    input wire logic bip_enable,
    // Link
    e3_oh_link.device link
);
    import e3_oh_pkg::*;

    typedef enum logic [1:0] {IDLE = 2'b00, SEND = 2'b01} dev_state_t;

    dev_state_t state, next_state;
    logic [2:0] div, next_div;
    logic [IDX_W-1:0] idx, next_idx;
    oh_word_t shadow, next_shadow;
    logic pend, next_pend;
    logic pend_bip, next_pend_bip;
    logic bip_on, next_bip_on;
    oh_word_t pend_word, next_pend_word;
    logic clk_q, next_clk_q;
    logic data_q, next_data_q;
    logic mark_q, next_mark_q;
    logic strb_q, next_strb_q;
    logic rise;

    assign rise = (div == DIV_LAST);

    always_comb begin
        next_div = div + 3'h1;
        next_clk_q = (next_div >= DIV_HALF) ? 1'b0 : 1'b1;
        next_state = state;
        next_idx = idx;
        next_shadow = shadow;
        next_bip_on = bip_on;
        next_pend = pend;
        next_pend_bip = pend_bip;
        next_pend_word = pend_word;
        next_data_q = data_q;
        next_mark_q = mark_q;
        next_strb_q = strb_q;
        // Newest frame wins if an older one is still waiting
        if (frame_done) begin
            next_pend = 1'b1;
            next_pend_word = overhead_word;
            next_pend_bip = bip_enable;
        end
        if (rise) begin
            next_strb_q = 1'b0;
            next_mark_q = 1'b0;
            case (state)
                IDLE: begin
                    if (pend) begin
                        next_shadow = pend_word;
                        next_bip_on = pend_bip;
                        next_pend = frame_done;
                        next_idx = IDX_FIRST;
                        next_state = SEND;
                    end
                end
                SEND: begin
                    next_strb_q = 1'b1;
                    next_mark_q = (idx == IDX_FIRST);
                    // MSB first: alignment bits, A, N, then BIP-4
                    next_data_q = shadow[IDX_W'(OH_BITS-1) - idx];
                    // Unprocessed BIP-4 positions are driven low
                    if (idx >= IDX_BIP_FIRST && !bip_on) begin
                        next_data_q = 1'b0;
                    end
                    next_idx = idx + 4'h1;
                    if (idx == IDX_LAST) begin
                        next_state = IDLE;
                    end
                end
                default: next_state = IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= IDLE;
            div <= 3'h0;
            idx <= 4'h0;
            shadow <= '0;
            bip_on <= 1'b0;
            pend <= 1'b0;
            pend_bip <= 1'b0;
            pend_word <= '0;
            clk_q <= 1'b1;
            data_q <= 1'b0;
            mark_q <= 1'b0;
            strb_q <= 1'b0;
        end else begin
            state <= next_state;
            div <= next_div;
            idx <= next_idx;
            shadow <= next_shadow;
            bip_on <= next_bip_on;
            pend <= next_pend;
            pend_bip <= next_pend_bip;
            pend_word <= next_pend_word;
            clk_q <= next_clk_q;
            data_q <= next_data_q;
            mark_q <= next_mark_q;
            strb_q <= next_strb_q;
        end
    end

    assign link.receive_line_clock = clk_q;
    assign link.overhead_serial_out = data_q;
    assign link.overhead_frame_marker = mark_q;
    assign link.overhead_bit_strobe = strb_q;
endmodule : e3_oh_device
`default_nettype wire

// >>> e3_oh_terminal.sv
// Terminal end: samples the link on falling line-clock edges and rebuilds the overhead word.
// Assumes the link is driven from flip-flops of the device end on the same mclk.
`timescale 1ns/10ps
`default_nettype none
module e3_oh_terminal (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Link
    e3_oh_link.terminal link,
    // User side
    output var logic word_valid,
    output var e3_oh_pkg::oh_word_t word_out,
    output var logic [e3_oh_pkg::IDX_W-1:0] bit_index,
    output var logic bit_valid,
    output var logic bit_value
);
    import e3_oh_pkg::*;

    logic [3:0] pin;
    logic clk_d, next_clk_d;
    logic in_frame, next_in_frame;
    logic [IDX_W-1:0] cnt, next_cnt;
    oh_word_t acc, next_acc;
    logic next_word_valid, next_bit_valid, next_bit_value;
    oh_word_t next_word_out;
    logic [IDX_W-1:0] next_bit_index;
    logic fall;

    // Clock, data, marker, strobe; same mclk domain, so no synchroniser
    assign pin = {link.receive_line_clock, link.overhead_serial_out,
                  link.overhead_frame_marker, link.overhead_bit_strobe};

    assign fall = clk_d && !pin[3];

    always_comb begin
        next_clk_d = pin[3];
        next_in_frame = in_frame;
        next_cnt = cnt;
        next_acc = acc;
        next_word_valid = 1'b0;
        next_word_out = word_out;
        next_bit_valid = 1'b0;
        next_bit_index = bit_index;
        next_bit_value = bit_value;
        // All three pins taken on the same falling edge
        if (fall && pin[0]) begin
            if (pin[1]) begin
                next_cnt = IDX_FIRST;
                next_in_frame = 1'b1;
            end
            if (pin[1] || in_frame) begin
                next_bit_valid = 1'b1;
                next_bit_index = pin[1] ? IDX_FIRST : cnt;
                next_bit_value = pin[2];
                next_acc[IDX_W'(OH_BITS-1) - next_bit_index] = pin[2];
                next_cnt = next_bit_index + 4'h1;
                if (next_bit_index == IDX_LAST) begin
                    next_word_valid = 1'b1;
                    next_word_out = next_acc;
                    next_in_frame = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            // Line clock idles high in reset; avoids a false fall at release
            clk_d <= 1'b1;
            in_frame <= 1'b0;
            cnt <= 4'h0;
            acc <= '0;
            word_valid <= 1'b0;
            word_out <= '0;
            bit_valid <= 1'b0;
            bit_index <= 4'h0;
            bit_value <= 1'b0;
        end else begin
            clk_d <= next_clk_d;
            in_frame <= next_in_frame;
            cnt <= next_cnt;
            acc <= next_acc;
            word_valid <= next_word_valid;
            word_out <= next_word_out;
            bit_valid <= next_bit_valid;
            bit_index <= next_bit_index;
            bit_value <= next_bit_value;
        end
    end
endmodule : e3_oh_terminal
`default_nettype wire

// >>> e3_oh_link_properties.sv
// Checker for the overhead strobe link between the two ends.
// Assumes one mclk domain; takes the link signals as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module e3_oh_link_properties (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Link
    input wire logic receive_line_clock,
    input wire logic overhead_serial_out,
    input wire logic overhead_frame_marker,
    input wire logic overhead_bit_strobe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_moves_on_rise: assert property (($changed(overhead_serial_out) ||
        $changed(overhead_frame_marker) || $changed(overhead_bit_strobe))
        |-> $rose(receive_line_clock)) else $error("link output moved off line rise");
    a_clk_high_four: assert property ($rose(receive_line_clock) |->
        receive_line_clock[*4] ##1 !receive_line_clock) else $error("line clock high phase");
    a_clk_low_four: assert property ($fell(receive_line_clock) |->
        !receive_line_clock[*4] ##1 receive_line_clock) else $error("line clock low phase");
    a_marker_needs_strobe: assert property (overhead_frame_marker |->
        overhead_bit_strobe) else $error("marker without strobe");
    a_first_is_marked: assert property ($rose(overhead_bit_strobe) |->
        overhead_frame_marker) else $error("first strobe unmarked");
    a_marker_one_period: assert property ($rose(overhead_frame_marker) |->
        overhead_frame_marker[*8] ##1 !overhead_frame_marker) else $error("marker length");
    a_strobe_sixteen: assert property ($rose(overhead_bit_strobe) |->
        ##127 overhead_bit_strobe ##1 !overhead_bit_strobe) else $error("strobe run length");
    a_gap_after: assert property ($fell(overhead_bit_strobe) |->
        !overhead_bit_strobe[*8]) else $error("no idle period after frame");
endmodule : e3_oh_link_properties
`default_nettype wire

// >>> tb_top.sv
// Testbench joining both ends over the link, random and corner overhead words.
// Assumes the package constants and the hand-over timing of both ends.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import e3_oh_pkg::*;
    logic mclk, rst_b, frame_done, bip_enable, word_valid, bit_valid, bit_value, lc_q;
    oh_word_t overhead_word, word_out, exp, wire_word;
    logic [IDX_W-1:0] bit_index;
    int miscompares = 0, checked = 0, wire_cnt = 0, bidx = 0;
    e3_oh_link u_e3_oh_link ();
    e3_oh_device u_e3_oh_device (.mclk(mclk), .rst_b(rst_b), .frame_done(frame_done),
        .overhead_word(overhead_word), .bip_enable(bip_enable), .link(u_e3_oh_link));
    e3_oh_terminal u_e3_oh_terminal (.mclk(mclk), .rst_b(rst_b), .link(u_e3_oh_link),
        .word_valid(word_valid), .word_out(word_out), .bit_index(bit_index),
        .bit_valid(bit_valid), .bit_value(bit_value));
    e3_oh_link_properties u_e3_oh_link_properties (.mclk(mclk), .rst_b(rst_b),
        .receive_line_clock(u_e3_oh_link.receive_line_clock),
        .overhead_serial_out(u_e3_oh_link.overhead_serial_out),
        .overhead_frame_marker(u_e3_oh_link.overhead_frame_marker),
        .overhead_bit_strobe(u_e3_oh_link.overhead_bit_strobe));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : check
    task close_out;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out
    // Own view of the wire, taken at falling line edges like a terminal would
    always @(posedge mclk) begin
        lc_q <= u_e3_oh_link.receive_line_clock;
        if (lc_q && !u_e3_oh_link.receive_line_clock && u_e3_oh_link.overhead_bit_strobe) begin
            wire_word <= {wire_word[14:0], u_e3_oh_link.overhead_serial_out};
            wire_cnt <= u_e3_oh_link.overhead_frame_marker ? 1 : wire_cnt + 1;
        end
    end
    always @(posedge mclk) begin
        if (bit_valid === 1'b1) begin
            check("bit_index", 16'(bit_index), 16'(bidx));
            check("bit_value", 16'(bit_value), 16'(exp[15 - bidx]));
            bidx <= (bidx + 1) % 16;
        end
    end
    function automatic oh_word_t expect_word(input oh_word_t w, input logic b);
        return b ? w : {w[15:4], 4'h0};
    endfunction : expect_word
    task automatic wait_word();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (word_valid !== 1'b1 && n < 400);
        check("word_valid", 16'(word_valid), 16'h0001);
        check("word_out", word_out, exp);
        check("wire_word", wire_word, exp);
        check("wire_cnt", 16'(wire_cnt), 16'h0010);
    endtask : wait_word
    task automatic send(input oh_word_t w, input logic b, input logic twice);
        @(posedge mclk);
        frame_done <= 1'b1;
        overhead_word <= w;
        bip_enable <= b;
        // Non-blocking so the last bit check of the previous frame keeps its word
        exp <= expect_word(w, b);
        @(posedge mclk);
        frame_done <= 1'b0;
        if (twice) begin
            // Second copy arrives mid-frame and must wait in the one-deep queue
            repeat (40) @(posedge mclk);
            frame_done <= 1'b1;
            @(posedge mclk);
            frame_done <= 1'b0;
            wait_word();
        end
        wait_word();
    endtask : send
    initial begin
        frame_done = 1'b0;
        overhead_word = 16'h0000;
        bip_enable = 1'b0;
        rst_b = 1'b0;
        void'($urandom(32'h28EB));
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            if (i == 12) begin
                @(posedge mclk);
                rst_b <= 1'b0;
                @(posedge mclk);
                #1;
                check("word_out_reset", word_out, 16'h0000);
                @(posedge mclk);
                rst_b <= 1'b1;
            end
            send(i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($urandom),
                i == 0 ? 1'b0 : i == 1 ? 1'b1 : 1'($urandom), i % 6 == 3);
        end
        close_out;
    end
    // Hang guard, well past 28 frames of about 136 cycles each
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out;
    end
endmodule : tb_top
`default_nettype wire
